// >>> verilog/dsdfo_delta_freq.sv
`timescale 1ns/1ps
`include "dsdfo_consts.svh"

// What this block does
// - The software delta is the target deviation only when enabled and freerun mode is 11.
// - Fast select reaches the software target at once, otherwise via filter and slope limiter.
// - The software delta is ignored when disabled or not in freerun mode.
// - The 15-bit delta field is a two's complement value in center frequency units.
// - The present deviation is reported as a 15-bit signed field in the same units.
// - In fast mode the filter and limiter are bypassed, so the reported offset stands still.
// - Bit 15 of the offset register always reads zero.
// - The offset register is read-only; writes to it change nothing.
module dsdfo_delta_freq #(
  parameter int FILT_SHIFT = `DSDFO_FILT_SHIFT,
  parameter int SLOPE_MAX  = `DSDFO_SLOPE_MAX
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // Host register port
  input  wire dsdfo_pkg::dsdfo_host_req_t host_req,
  output logic [15:0]                   host_rdata,
  output logic                          host_rvalid,
  // Loop control and reference path
  input  wire dsdfo_pkg::dsdfo_ctrl_t   ctrl,
  input  wire dsdfo_pkg::dsdfo_freq_t   loop_target,
  // Deviation applied to the oscillator and offset reported to the host
  output dsdfo_pkg::dsdfo_freq_t        pll_freq_delta,
  output dsdfo_pkg::dsdfo_freq_t        current_freq_offset
);

  // Refuse settings the slew arithmetic cannot serve
  if (FILT_SHIFT < 0 || FILT_SHIFT > 15) begin : g_bad_shift
    $error("FILT_SHIFT out of range");
  end
  if (SLOPE_MAX < 1 || SLOPE_MAX > 16383) begin : g_bad_slope
    $error("SLOPE_MAX out of range");
  end

  // One filtered, slope limited step from cur toward tgt
  function automatic dsdfo_pkg::dsdfo_freq_t slew_step(input dsdfo_pkg::dsdfo_freq_t cur,
                                                       input dsdfo_pkg::dsdfo_freq_t tgt);
    logic signed [15:0] diff;
    logic        [15:0] mag;
    logic        [15:0] stp;
    diff = 16'(tgt) - 16'(cur);
    mag  = diff[15] ? 16'(-diff) : 16'(diff);
    stp  = mag >> FILT_SHIFT;
    if (stp == 16'h0000 && mag != 16'h0000) begin
      stp = 16'h0001;
    end
    if (stp > 16'(SLOPE_MAX)) begin
      stp = 16'(SLOPE_MAX);
    end
    slew_step = diff[15] ? 15'(16'(cur) - stp) : 15'(16'(cur) + stp);
  endfunction

  dsdfo_pkg::dsdfo_freq_t sw_delta_freq;
  dsdfo_pkg::dsdfo_freq_t next_sw_delta_freq;
  dsdfo_pkg::dsdfo_freq_t next_pll_freq_delta;
  dsdfo_pkg::dsdfo_freq_t next_current_freq_offset;
  dsdfo_pkg::dsdfo_freq_t target;
  logic [15:0]            next_host_rdata;
  logic                   next_host_rvalid;
  logic                   sw_active;
  logic                   fast;

  // Target selection and fast path
  always_comb begin
    sw_active = ctrl.sw_freq_enable &&
                (ctrl.freerun_mode_select == `DSDFO_FREERUN_CODE);
    target    = sw_active ? sw_delta_freq : loop_target;
    fast      = sw_active && ctrl.sw_fast_select;
  end

  // Loop frequency state
  always_comb begin
    if (fast) begin
      next_pll_freq_delta      = target;
      next_current_freq_offset = current_freq_offset;
    end else begin
      next_current_freq_offset = slew_step(current_freq_offset, target);
      next_pll_freq_delta      = next_current_freq_offset;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_freq_delta      <= `DSDFO_RST_FREQ;
      current_freq_offset <= `DSDFO_RST_FREQ;
    end else begin
      pll_freq_delta      <= next_pll_freq_delta;
      current_freq_offset <= next_current_freq_offset;
    end
  end

  // Host writes and reads
  always_comb begin
    next_sw_delta_freq = sw_delta_freq;
    next_host_rdata    = host_rdata;
    next_host_rvalid   = 1'b0;
    if (host_req.wr && host_req.addr == `DSDFO_OFS_SW_DELTA) begin
      next_sw_delta_freq = host_req.wdata[`DSDFO_FREQ_MSB:0];
    end
    if (host_req.rd) begin
      next_host_rvalid = 1'b1;
      case (host_req.addr)
        `DSDFO_OFS_SW_DELTA:   next_host_rdata = {1'b0, sw_delta_freq};
        `DSDFO_OFS_CUR_OFFSET: next_host_rdata = {1'b0, current_freq_offset};
        default:               next_host_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_delta_freq <= `DSDFO_RST_SW_DELTA;
      host_rdata    <= `DSDFO_RST_RDATA;
      host_rvalid   <= 1'b0;
    end else begin
      sw_delta_freq <= next_sw_delta_freq;
      host_rdata    <= next_host_rdata;
      host_rvalid   <= next_host_rvalid;
    end
  end

  // Previous offset, kept for the slope check
  dsdfo_pkg::dsdfo_freq_t prev_offset;
  dsdfo_pkg::dsdfo_freq_t next_prev_offset;
  logic signed [15:0]     step_now;

  // Offset one edge back
  always_comb begin
    next_prev_offset = current_freq_offset;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_offset <= `DSDFO_RST_FREQ;
    end else begin
      prev_offset <= next_prev_offset;
    end
  end

  // Signed step taken over the last edge
  assign step_now = 16'(current_freq_offset) - 16'(prev_offset);

  // Host and fast mode sequences
  sequence s_read_offset;
    host_req.rd && host_req.addr == `DSDFO_OFS_CUR_OFFSET;
  endsequence

  sequence s_fast_sw;
    sw_active && ctrl.sw_fast_select;
  endsequence

  sequence s_write_offset;
    host_req.wr && host_req.addr == `DSDFO_OFS_CUR_OFFSET;
  endsequence

  // Loop checks
  a_fast_reach_target: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_fast_sw |=> pll_freq_delta == $past(sw_delta_freq))
    else $error("fast mode did not apply software delta");

  a_sw_mode_used: assert property (@(posedge core_clk) disable iff (!rst_n)
    sw_active && !ctrl.sw_fast_select && current_freq_offset == sw_delta_freq
    |=> current_freq_offset == $past(sw_delta_freq))
    else $error("settled offset left software target");

  a_ignore_delta: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sw_active && current_freq_offset == loop_target |=> current_freq_offset == $past(loop_target)
    && pll_freq_delta == current_freq_offset)
    else $error("software delta leaked into loop");

  a_slew_bounded: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(fast) |-> (step_now <= 16'(SLOPE_MAX)) && (step_now >= -16'(SLOPE_MAX)))
    else $error("slope limit exceeded");

  a_fast_needs_sw: assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl.sw_fast_select && !sw_active && current_freq_offset != target
    |=> current_freq_offset != $past(current_freq_offset))
    else $error("fast select acted without software control");

  // Host port and fast freeze checks, then applied deviation and tracking checks
  a_delta_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    host_req.wr && host_req.addr == `DSDFO_OFS_SW_DELTA
    |=> sw_delta_freq == $past(host_req.wdata[14:0]))
    else $error("delta write not stored");

  a_offset_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_read_offset |=> host_rvalid && host_rdata == {1'b0, $past(current_freq_offset)})
    else $error("offset read wrong");

  a_fast_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_fast_sw |=> $stable(current_freq_offset))
    else $error("offset moved in fast mode");

  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    host_rvalid && $past(host_req.addr) == `DSDFO_OFS_CUR_OFFSET |-> !host_rdata[15])
    else $error("reserved bit set");

  a_ro_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_write_offset |=> $stable(sw_delta_freq))
    else $error("write to read-only register had effect");

  a_ro_state_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_write_offset ##0 (!fast && current_freq_offset == target)
    |=> $stable(current_freq_offset))
    else $error("write to read-only register moved the loop");

  a_rvalid_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    !host_req.rd |=> !host_rvalid)
    else $error("read valid without a read");

  a_delta_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
    host_req.rd && host_req.addr == `DSDFO_OFS_SW_DELTA
    |=> host_rdata == {1'b0, $past(sw_delta_freq)})
    else $error("delta read wrong");

  a_pll_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    !fast |=> pll_freq_delta == current_freq_offset)
    else $error("applied deviation differs from reported offset");

  a_offset_tracks: assert property (@(posedge core_clk) disable iff (!rst_n)
    !fast && current_freq_offset != target |=> current_freq_offset != $past(current_freq_offset))
    else $error("offset not following loop");

endmodule // dsdfo_delta_freq

// >>> verilog/dsdfo_consts.svh
`ifndef DSDFO_CONSTS_SVH
`define DSDFO_CONSTS_SVH

// Register offsets on the host port
`define DSDFO_OFS_SW_DELTA    8'h44
`define DSDFO_OFS_CUR_OFFSET  8'h45

// Field positions
`define DSDFO_FREQ_MSB        14
`define DSDFO_RSVD_BIT        15

// Reset values
`define DSDFO_RST_SW_DELTA    15'h0000
`define DSDFO_RST_FREQ        15'h0000
`define DSDFO_RST_RDATA       16'h0000

// Freerun mode code that lets software steer the loop
`define DSDFO_FREERUN_CODE    2'h3

// Default loop filter shift and slope limit per cycle
`define DSDFO_FILT_SHIFT      4
`define DSDFO_SLOPE_MAX       64

`endif

// >>> verilog/dsdfo_pkg.sv
package dsdfo_pkg;

  // Signed frequency word, same units as the center frequency number
  typedef logic signed [14:0] dsdfo_freq_t;

  // One host access, at most one of wr and rd per cycle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } dsdfo_host_req_t;

  // Loop control bits held in the control registers elsewhere
  typedef struct packed {
    logic       sw_freq_enable;
    logic       sw_fast_select;
    logic [1:0] freerun_mode_select;
  } dsdfo_ctrl_t;

endpackage

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "dsdfo_consts.svh"

// Counts every compare and reports any mismatch
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb;
  logic                       core_clk;
  logic                       rst_n;
  dsdfo_pkg::dsdfo_host_req_t host_req;
  logic [15:0]                host_rdata;
  logic                       host_rvalid;
  dsdfo_pkg::dsdfo_ctrl_t     ctrl;
  dsdfo_pkg::dsdfo_freq_t     loop_target;
  dsdfo_pkg::dsdfo_freq_t     pll_freq_delta;
  dsdfo_pkg::dsdfo_freq_t     current_freq_offset;
  logic [15:0]                rv;
  int                         err_count;
  int                         n_tests;

  dsdfo_delta_freq dsdfo_delta_freq_i (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .host_req            (host_req),
    .host_rdata          (host_rdata),
    .host_rvalid         (host_rvalid),
    .ctrl                (ctrl),
    .loop_target         (loop_target),
    .pll_freq_delta      (pll_freq_delta),
    .current_freq_offset (current_freq_offset)
  );

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  // Verdict and end of run
  task automatic close_out();
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One host write, strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    host_req.wr = 1'b0;
  endtask

  // One host read, waits a bounded time for the answer
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int i;
    @(negedge core_clk);
    host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge core_clk);
    host_req.rd = 1'b0;
    for (i = 0; i < 4 && host_rvalid !== 1'b1; i++) @(negedge core_clk);
    d = host_rdata;
    if (host_rvalid !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask

  // Waits a bounded time for the offset to settle on a value
  task automatic settle(input dsdfo_pkg::dsdfo_freq_t e);
    int i;
    for (i = 0; i < 300 && current_freq_offset !== e; i++) @(negedge core_clk);
    `CHK("settled offset", e, current_freq_offset)
    `CHK("applied delta", e, pll_freq_delta)
    if (current_freq_offset !== e) close_out();
  endtask

  // Steps the control inputs and checks each reaction
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    err_count = 0;
    n_tests = 0;
    host_req = '0;
    ctrl = '0;
    loop_target = 15'h0000;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    rd(`DSDFO_OFS_CUR_OFFSET, rv);
    `CHK("offset after reset", 16'h0000, rv)
    @(negedge core_clk);
    `CHK("rvalid pulse", 1'b0, host_rvalid)
    wr(`DSDFO_OFS_SW_DELTA, 16'h7FFB);
    rd(`DSDFO_OFS_SW_DELTA, rv);
    `CHK("delta readback", 16'h7FFB, rv)
    rd(8'h50, rv);
    `CHK("unmapped read", 16'h0000, rv)
    // Fast steering applies -5 at once and freezes the report
    ctrl = '{sw_freq_enable: 1'b1, sw_fast_select: 1'b1, freerun_mode_select: 2'h3};
    repeat (2) @(negedge core_clk);
    `CHK("fast delta", 15'h7FFB, pll_freq_delta)
    `CHK("fast frozen", 15'h0000, current_freq_offset)
    // Disabled: delta ignored, slews toward the loop target
    ctrl.sw_freq_enable = 1'b0;
    loop_target = 15'h0064;
    @(negedge core_clk);
    `CHK("first step", 15'h0006, current_freq_offset)
    settle(15'h0064);
    // Not freerun: still ignored
    ctrl = '{sw_freq_enable: 1'b1, sw_fast_select: 1'b0, freerun_mode_select: 2'h2};
    repeat (20) @(negedge core_clk);
    `CHK("mode ignored", 15'h0064, current_freq_offset)
    // Freerun steering through filter toward -5
    ctrl.freerun_mode_select = 2'h3;
    @(negedge core_clk);
    `CHK("slow step", 15'h005E, current_freq_offset)
    settle(15'h7FFB);
    wr(`DSDFO_OFS_CUR_OFFSET, 16'h1234);
    rd(`DSDFO_OFS_CUR_OFFSET, rv);
    `CHK("offset read", 16'h7FFB, rv)
    `CHK("offset kept", 15'h7FFB, current_freq_offset)
    close_out();
  end
endmodule // tb
